/* logic/regsem_pkg.sv */
// Behaviour
// - write-once field accepts one write per reset
// - write-once lock tracked per byte
// - writing one clears bit, zero no effect
// - writing one sets bit, zero no effect
// - write-only field captures writes, read undefined
// - read-only field ignores software writes
// - done flag updated by hardware on completion
// - hardware may update field independent of software
// - read-as-zero returns zero, ignores writes
// - writing one to must-be-zero faults
// - fault-on-access fields fault per access type
// - registers take reset value on warm reset, cold fields only on power_good
// - unspecified reset digits leave state undefined
// - cold fields survive warm reset, cleared by power_good
// - reset-applied value takes effect at warm reset
// - value field read-only, constant under all conditions
// - per-core register replicated for each core
// - alias address reaches target storage
// - index register selects, data register accesses
// - default strides 1, 16, 4 by space
// - broadcast address writes and reads whole group
package regsem_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLD_W  = 8;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_SETREG  = 8'h08;
  localparam logic [7:0] OFS_WONCE   = 8'h0c;
  localparam logic [7:0] OFS_WONLY   = 8'h10;
  localparam logic [7:0] OFS_OPSTAT  = 8'h14;
  localparam logic [7:0] OFS_VALUE   = 8'h18;
  localparam logic [7:0] OFS_COLD    = 8'h1c;
  localparam logic [7:0] OFS_PEND    = 8'h20;
  localparam logic [7:0] OFS_PERCORE = 8'h24;
  localparam logic [7:0] OFS_ALIAS   = 8'h28;
  localparam logic [7:0] OFS_INDEX   = 8'h2c;
  localparam logic [7:0] OFS_DATA    = 8'h30;
  localparam logic [7:0] OFS_BCAST   = 8'h34;
  localparam logic [7:0] OFS_GPRD    = 8'h38;
  localparam logic [7:0] OFS_GPWR    = 8'h3c;
  localparam logic [7:0] OFS_RANGE   = 8'h40;
  localparam int RANGE_N             = 4;
  // default strides between ranged instances
  localparam int STRIDE_MSR          = 1;
  localparam int STRIDE_CPUID        = 1;
  localparam int STRIDE_APIC         = 16;
  localparam int STRIDE_INDEXED      = 1;
  localparam int STRIDE_OTHER        = 4;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  MBZ_MASK    = 8'hff;
  localparam int          MBZ_LSB     = 8;
  localparam logic [31:0] WONCE_RST   = 32'h0000_0000;
  localparam logic [31:0] COLD_RST    = 32'h0000_0000;
  localparam logic [31:0] PEND_RST    = 32'h0000_0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [7:0]  FLD_RST     = 8'h00;
endpackage

/* logic/regsem_bank.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module regsem_bank #(
  parameter int          NUM_CORES = 2,
  parameter int          IDX_DEPTH = 16,
  parameter logic [31:0] VALUE_ID  = 32'h0000_0a01  // arbitrary value
) (
  input  wire logic                                     pclk,          // bus clock
  input  wire logic                                     presetn,       // warm reset, low
  input  wire logic                                     power_good,    // cold reset when low
  input  wire logic                                     psel,          // apb select
  input  wire logic                                     penable,       // apb enable
  input  wire logic                                     pwrite,        // apb direction
  input  wire logic [regsem_pkg::ADDR_W-1:0]            paddr,         // apb byte address
  input  wire logic [regsem_pkg::DATA_W-1:0]            pwdata,        // apb write data
  input  wire logic [3:0]                               pstrb,         // apb byte strobes
  input  wire logic [$clog2(NUM_CORES)-1:0]             core_id,       // issuing core
  output logic                                          pready,        // apb ready
  output logic [regsem_pkg::DATA_W-1:0]                 prdata,        // apb read data
  output logic                                          pslverr,       // fault answer
  input  wire logic [regsem_pkg::FLD_W-1:0]             status_event,  // hw sets status bits
  input  wire logic [regsem_pkg::FLD_W-1:0]             set_clear,     // hw clears set bits
  input  wire logic                                     op_done,       // operation complete
  output logic [regsem_pkg::FLD_W-1:0]                  ctrl_out,      // control field
  output logic [regsem_pkg::FLD_W-1:0]                  set_out,       // write-one-set field
  output logic [regsem_pkg::DATA_W-1:0]                 wonce_out,     // write-once word
  output logic [regsem_pkg::DATA_W-1:0]                 cmd_out,       // write-only command
  output logic                                          op_start,      // command pulse
  output logic [regsem_pkg::DATA_W-1:0]                 applied_out,   // active applied value
  output logic [regsem_pkg::DATA_W-1:0]                 cold_out,      // cold field
  output logic                                          gp_fault       // fault pulse
);
  localparam int CORE_W = $clog2(NUM_CORES);
  localparam int IDX_W  = $clog2(IDX_DEPTH);

  logic [7:0]  ctrl_reg;
  logic [7:0]  status_reg;
  logic [7:0]  setbits_reg;
  logic [31:0] wonce_reg;
  logic [3:0]  lock_reg;
  logic [31:0] cmd_reg;
  logic        start_reg;
  logic        done_reg;
  logic [31:0] cold_reg;
  logic [31:0] pend_reg;
  logic [31:0] active_reg;
  logic        applied_reg;
  logic [31:0] percore_reg [NUM_CORES];
  logic [31:0] range_reg [regsem_pkg::RANGE_N];
  logic [IDX_W-1:0] index_reg;
  logic [31:0] idx_mem [IDX_DEPTH];
  logic [31:0] gprd_reg;
  logic [31:0] gpwr_reg;
  logic [31:0] prdata_reg;
  logic        fault_reg;
  logic [31:0] bcast_rd;
  logic [31:0] rd_next;
  logic        hit;
  logic        fault;
  logic        wr;
  logic        acc;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // index of a ranged instance at the default stride, or -1 when outside
  function automatic int range_idx(input logic [7:0] a);
    int d;
    d = int'(a) - int'(regsem_pkg::OFS_RANGE);
    if (d >= 0 && d < regsem_pkg::RANGE_N * regsem_pkg::STRIDE_OTHER &&
        (d % regsem_pkg::STRIDE_OTHER) == 0) begin
      return d / regsem_pkg::STRIDE_OTHER;
    end
    return -1;
  endfunction

  function automatic logic is_ctrl(input logic [7:0] a);
    return a == regsem_pkg::OFS_CTRL || a == regsem_pkg::OFS_ALIAS;
  endfunction

  assign acc = psel & penable;
  assign wr  = acc & pwrite & ~fault;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      regsem_pkg::OFS_CTRL, regsem_pkg::OFS_STATUS, regsem_pkg::OFS_SETREG,
      regsem_pkg::OFS_WONCE, regsem_pkg::OFS_WONLY, regsem_pkg::OFS_OPSTAT,
      regsem_pkg::OFS_VALUE, regsem_pkg::OFS_COLD, regsem_pkg::OFS_PEND,
      regsem_pkg::OFS_PERCORE, regsem_pkg::OFS_ALIAS, regsem_pkg::OFS_INDEX,
      regsem_pkg::OFS_DATA, regsem_pkg::OFS_BCAST, regsem_pkg::OFS_GPRD,
      regsem_pkg::OFS_GPWR: hit = 1'b1;
      default: hit = (range_idx(paddr) >= 0);
    endcase
  end

  // faults block the update entirely
  always_comb begin
    fault = ~hit;
    if (pwrite && is_ctrl(paddr) && pstrb[1] &&
        (pwdata[regsem_pkg::MBZ_LSB +: 8] & regsem_pkg::MBZ_MASK) != 8'h00) begin
      fault = 1'b1;
    end
    if (!pwrite && paddr == regsem_pkg::OFS_GPRD) begin
      fault = 1'b1;
    end
    if (pwrite && paddr == regsem_pkg::OFS_GPWR) begin
      fault = 1'b1;
    end
  end

  assign pready   = 1'b1;
  assign pslverr  = acc & fault;
  assign prdata   = prdata_reg;
  assign gp_fault = fault_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= acc & fault;
    end
  end

  // control: low byte read-write, next byte must be zero, rest read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= regsem_pkg::CTRL_RST;
    end else if (wr && is_ctrl(paddr) && pstrb[0]) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= regsem_pkg::FLD_RST;
    end else if (wr && paddr == regsem_pkg::OFS_STATUS && pstrb[0]) begin
      status_reg <= (status_reg & ~pwdata[7:0]) | status_event;
    end else begin
      status_reg <= status_reg | status_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setbits_reg <= regsem_pkg::FLD_RST;
    end else if (wr && paddr == regsem_pkg::OFS_SETREG && pstrb[0]) begin
      setbits_reg <= (setbits_reg & ~set_clear) | pwdata[7:0];
    end else begin
      setbits_reg <= setbits_reg & ~set_clear;
    end
  end

  // write-once: each byte locks on its own first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wonce_reg <= regsem_pkg::WONCE_RST;
      lock_reg  <= 4'h0;
    end else if (wr && paddr == regsem_pkg::OFS_WONCE) begin
      wonce_reg <= merge(wonce_reg, pwdata, pstrb & ~lock_reg);
      lock_reg  <= lock_reg | pstrb;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg   <= regsem_pkg::WORD_RST;
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr && paddr == regsem_pkg::OFS_WONLY;
      if (wr && paddr == regsem_pkg::OFS_WONLY) begin
        cmd_reg <= merge(cmd_reg, pwdata, pstrb);
      end
    end
  end

  // completion wins over a new start in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (op_done) begin
      done_reg <= 1'b1;
    end else if (start_reg) begin
      done_reg <= 1'b0;
    end
  end

  // cold domain: only power_good clears it
  always_ff @(posedge pclk or negedge power_good) begin
    if (!power_good) begin
      cold_reg <= regsem_pkg::COLD_RST;
      pend_reg <= regsem_pkg::PEND_RST;
    end else if (wr && paddr == regsem_pkg::OFS_COLD) begin
      cold_reg <= merge(cold_reg, pwdata, pstrb);
    end else if (wr && paddr == regsem_pkg::OFS_PEND) begin
      pend_reg <= merge(pend_reg, pwdata, pstrb);
    end
  end

  // pending value is loaded in the first cycle after a warm reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg  <= regsem_pkg::WORD_RST;
      applied_reg <= 1'b0;
    end else if (!applied_reg) begin
      active_reg  <= pend_reg;
      applied_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        percore_reg[c] <= regsem_pkg::WORD_RST;
      end
    end else if (wr && paddr == regsem_pkg::OFS_PERCORE && int'(core_id) < NUM_CORES) begin
      percore_reg[core_id] <= merge(percore_reg[core_id], pwdata, pstrb);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < regsem_pkg::RANGE_N; gi++) begin : g_range
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          range_reg[gi] <= regsem_pkg::WORD_RST;
        end else if (wr && range_idx(paddr) == gi) begin
          range_reg[gi] <= merge(range_reg[gi], pwdata, pstrb);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_reg <= '0;
    end else if (wr && paddr == regsem_pkg::OFS_INDEX && pstrb[0]) begin
      index_reg <= pwdata[IDX_W-1:0];
    end
  end

  // indexed storage has no reset: contents are undefined after any reset
  always_ff @(posedge pclk) begin
    if (wr && paddr == regsem_pkg::OFS_DATA) begin
      idx_mem[index_reg] <= merge(idx_mem[index_reg], pwdata, pstrb);
    end else if (wr && paddr == regsem_pkg::OFS_BCAST) begin
      for (int i = 0; i < IDX_DEPTH; i++) begin
        idx_mem[i] <= merge(idx_mem[i], pwdata, pstrb);
      end
    end
  end

  // group read folds all entries so one read sees the whole set
  always_comb begin
    bcast_rd = '0;
    for (int i = 0; i < IDX_DEPTH; i++) begin
      bcast_rd = bcast_rd | idx_mem[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gprd_reg <= regsem_pkg::WORD_RST;
    end else if (wr && paddr == regsem_pkg::OFS_GPRD) begin
      gprd_reg <= merge(gprd_reg, pwdata, pstrb);
    end
  end

  assign gpwr_reg = {24'h000000, status_reg};

  always_comb begin
    rd_next = '0;
    case (paddr)
      regsem_pkg::OFS_CTRL:    rd_next = {24'h000000, ctrl_reg};
      regsem_pkg::OFS_ALIAS:   rd_next = {24'h000000, ctrl_reg};
      regsem_pkg::OFS_STATUS:  rd_next = {24'h000000, status_reg};
      regsem_pkg::OFS_SETREG:  rd_next = {24'h000000, setbits_reg};
      regsem_pkg::OFS_WONCE:   rd_next = wonce_reg;
      regsem_pkg::OFS_WONLY:   rd_next = '0;
      regsem_pkg::OFS_OPSTAT:  rd_next = {27'h0000000, lock_reg, done_reg};
      regsem_pkg::OFS_VALUE:   rd_next = VALUE_ID;
      regsem_pkg::OFS_COLD:    rd_next = cold_reg;
      regsem_pkg::OFS_PEND:    rd_next = pend_reg;
      regsem_pkg::OFS_PERCORE: begin
        if (int'(core_id) < NUM_CORES) begin
          rd_next = percore_reg[core_id];
        end
      end
      regsem_pkg::OFS_INDEX:   rd_next = {{(32-IDX_W){1'b0}}, index_reg};
      regsem_pkg::OFS_DATA:    rd_next = idx_mem[index_reg];
      regsem_pkg::OFS_BCAST:   rd_next = bcast_rd;
      regsem_pkg::OFS_GPWR:    rd_next = gpwr_reg;
      default: begin
        if (range_idx(paddr) >= 0) begin
          rd_next = range_reg[range_idx(paddr)];
        end
      end
    endcase
  end

  // read data captured in setup so the zero-wait access sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= regsem_pkg::WORD_RST;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  assign ctrl_out    = ctrl_reg;
  assign set_out     = setbits_reg;
  assign wonce_out   = wonce_reg;
  assign cmd_out     = cmd_reg;
  assign op_start    = start_reg;
  assign applied_out = active_reg;
  assign cold_out    = cold_reg;

  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == regsem_pkg::OFS_STATUS && pstrb[0] && status_event == 8'h00)
    |=> status_reg == ($past(status_reg) & ~$past(pwdata[7:0])))
    else $error("write-one-clear did not clear");

  a_w1s_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == regsem_pkg::OFS_SETREG && pstrb[0] && set_clear == 8'h00)
    |=> setbits_reg == ($past(setbits_reg) | $past(pwdata[7:0])))
    else $error("write-one-set wrong");

  a_wonce_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == regsem_pkg::OFS_WONCE && lock_reg[0])
    |=> wonce_reg[7:0] == $past(wonce_reg[7:0]))
    else $error("locked byte changed");

  a_mbz_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && is_ctrl(paddr) && pstrb[1] && pwdata[regsem_pkg::MBZ_LSB +: 8] != 8'h00)
    |-> pslverr ##1 (gp_fault && $stable(ctrl_reg)))
    else $error("must-be-zero write not faulted");

  a_gp_read: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == regsem_pkg::OFS_GPRD) |-> pslverr)
    else $error("fault on read missing");

  a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
    op_done |=> done_reg)
    else $error("done flag not set");

  a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (start_reg && !op_done) |=> !done_reg)
    else $error("done flag not cleared by start");

  a_value_const: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == regsem_pkg::OFS_VALUE) |=> prdata == VALUE_ID)
    else $error("value field wrong");

  a_alias_same: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == regsem_pkg::OFS_ALIAS && pstrb[0]) |=> ctrl_out == $past(pwdata[7:0]))
    else $error("alias write missed target");

  a_apply_load: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && !applied_reg) |=> applied_reg && applied_out == $past(pend_reg))
    else $error("pending value not applied");

  a_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (applied_reg && wr && paddr == regsem_pkg::OFS_PEND) |=> $stable(applied_out))
    else $error("pending value acted early");
endmodule // regsem_bank

/* dv/apb_core_model.sv */
`timescale 1ns/1ps
module apb_core_model (
  input  wire logic        pclk,     // bus clock
  input  wire logic        presetn,  // reset, low
  input  wire logic        req,      // start a transfer
  input  wire logic [45:0] req_word, // {write, addr, data, strb, core}
  input  wire logic        pready,   // slave ready
  input  wire logic [31:0] prdata,   // slave read data
  input  wire logic        pslverr,  // slave fault
  output logic             psel,     // apb select
  output logic             penable,  // apb enable
  output logic             pwrite,   // apb direction
  output logic [7:0]       paddr,    // apb address
  output logic [31:0]      pwdata,   // apb write data
  output logic [3:0]       pstrb,    // apb strobes
  output logic             core_id,  // issuing core
  output logic             done,     // finish pulse
  output logic [31:0]      rdata,    // taken read data
  output logic             err       // taken fault
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel <= 1'h0;
      penable <= 1'h0;
      done <= 1'h0;
      {pwrite, paddr, pwdata, pstrb, core_id} <= 46'h0;
    end else begin
      done <= 1'h0;
      if (req && !psel) begin
        psel <= 1'h1;
        {pwrite, paddr, pwdata, pstrb, core_id} <= req_word; // reserved bits as given
      end else if (psel && !penable) begin
        penable <= 1'h1;
      end else if (psel && pready) begin
        {rdata, err} <= {prdata, pslverr};
        done <= 1'h1;
        psel <= 1'h0;
        penable <= 1'h0;
        // released address and data lines flip so a stale address or data never looks valid
        {paddr, pwdata} <= ~{paddr, pwdata};
      end
    end
  end
endmodule // apb_core_model

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data;
                         logic [3:0] strb; logic cid; logic err;} row_t;
  localparam logic [31:0] id_word = 32'h0000_5a3c; // arbitrary value
  logic        pclk = 1'h0, presetn = 1'h1, power_good = 1'h1, req = 1'h0, op_done = 1'h0;
  logic        psel, penable, pwrite, pready, pslverr, core_id, done, err, op_start, gp_fault;
  logic [3:0]  pstrb;
  logic [7:0]  paddr, status_event = 8'h00, set_clear = 8'h00, ctrl_out, set_out;
  logic [31:0] pwdata, prdata, rdata, wonce_out, cmd_out, applied_out, cold_out;
  logic [45:0] req_word = 46'h0;
  int          err_total = 0, checks_done = 0;
  row_t        rows[$];
  always #5 pclk = ~pclk;
  regsem_bank #(.NUM_CORES(2), .IDX_DEPTH(16), .VALUE_ID(id_word)) DUT (
    .pclk, .presetn, .power_good, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .core_id,
    .pready, .prdata, .pslverr, .status_event, .set_clear, .op_done, .ctrl_out, .set_out,
    .wonce_out, .cmd_out, .op_start, .applied_out, .cold_out, .gp_fault);
  apb_core_model core_side (
    .pclk, .presetn, .req, .req_word, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .core_id, .done, .rdata, .err);
  task automatic test_done();
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  // bounded wait so a slave that never answers ends the run
  task automatic bus(input row_t r);
    int n;
    @(posedge pclk);
    req <= 1'h1;
    req_word <= r[46:1];
    @(posedge pclk);
    req <= 1'h0;
    for (n = 0; n < 20 && done !== 1'h1; n++) begin
      @(posedge pclk);
      #1;
    end
    if (done !== 1'h1) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic run();
    foreach (rows[i]) begin
      bus(rows[i]);
      if (!rows[i].wr) cmp($sformatf("rdata %h", rows[i].addr), rows[i].data, rdata);
      cmp($sformatf("pslverr %h", rows[i].addr), {31'h0, rows[i].err}, {31'h0, err});
    end
    rows.delete();
  endtask
  task automatic put(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
                     input logic e, input logic [3:0] s = 4'hf);
    rows.push_back('{w, a, d, s, c, e});
  endtask
  task automatic pw(input logic [7:0] a, input logic [31:0] d);
    put(1'h1, a, d, 1'h0, 1'h0);
  endtask
  task automatic pr(input logic [7:0] a, input logic [31:0] d);
    put(1'h0, a, d, 1'h0, 1'h0);
  endtask
  task automatic hw(input logic [7:0] ev, input logic [7:0] cl, input logic dn);
    @(posedge pclk);
    status_event <= ev;
    set_clear <= cl;
    op_done <= dn;
    @(posedge pclk);
    status_event <= 8'h00;
    set_clear <= 8'h00;
    op_done <= 1'h0;
  endtask
  task automatic rst(input logic cold);
    @(posedge pclk);
    presetn <= 1'h0;
    power_good <= ~cold;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    power_good <= 1'h1;
  endtask
  initial begin
    #1;
    presetn = 1'h0;
    power_good = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    power_good <= 1'h1;
    pr(regsem_pkg::OFS_CTRL, 32'h0);
    pw(regsem_pkg::OFS_CTRL, 32'ha5);
    pr(regsem_pkg::OFS_ALIAS, 32'ha5);
    pw(regsem_pkg::OFS_ALIAS, 32'h5a);
    pr(regsem_pkg::OFS_CTRL, 32'h5a);
    put(1'h1, regsem_pkg::OFS_CTRL, 32'h100, 1'h0, 1'h1);
    pr(regsem_pkg::OFS_CTRL, 32'h5a);
    pw(regsem_pkg::OFS_CTRL, 32'hffff_0033);
    pr(regsem_pkg::OFS_CTRL, 32'h33);
    pw(regsem_pkg::OFS_VALUE, 32'h0);
    pr(regsem_pkg::OFS_VALUE, id_word);
    put(1'h1, regsem_pkg::OFS_WONCE, 32'h1122_3344, 1'h0, 1'h0, 4'h1);
    pw(regsem_pkg::OFS_WONCE, 32'hffff_ffff);
    pr(regsem_pkg::OFS_WONCE, 32'hffff_ff44);
    pr(regsem_pkg::OFS_OPSTAT, 32'h1e);
    pw(regsem_pkg::OFS_GPRD, 32'h1);
    put(1'h0, regsem_pkg::OFS_GPRD, 32'h0, 1'h0, 1'h1);
    put(1'h1, regsem_pkg::OFS_GPWR, 32'h0, 1'h0, 1'h1);
    put(1'h0, 8'h50, 32'h0, 1'h0, 1'h1);
    put(1'h1, regsem_pkg::OFS_PERCORE, 32'h1, 1'h0, 1'h0);
    put(1'h1, regsem_pkg::OFS_PERCORE, 32'h2, 1'h1, 1'h0);
    put(1'h0, regsem_pkg::OFS_PERCORE, 32'h1, 1'h0, 1'h0);
    put(1'h0, regsem_pkg::OFS_PERCORE, 32'h2, 1'h1, 1'h0);
    pw(regsem_pkg::OFS_INDEX, 32'h3);
    pw(regsem_pkg::OFS_DATA, 32'habc);
    pw(regsem_pkg::OFS_INDEX, 32'h5);
    pw(regsem_pkg::OFS_DATA, 32'h123);
    pw(regsem_pkg::OFS_INDEX, 32'h3);
    pr(regsem_pkg::OFS_DATA, 32'habc);
    pw(regsem_pkg::OFS_BCAST, 32'hf0);
    pr(regsem_pkg::OFS_DATA, 32'hf0);
    pr(regsem_pkg::OFS_BCAST, 32'hf0);
    pw(regsem_pkg::OFS_SETREG, 32'h3);
    pw(regsem_pkg::OFS_SETREG, 32'h0);
    pr(regsem_pkg::OFS_SETREG, 32'h3);
    pw(regsem_pkg::OFS_COLD, 32'h77);
    pw(regsem_pkg::OFS_PEND, 32'h99);
    for (int i = 0; i < 4; i++) pw(regsem_pkg::OFS_RANGE + 8'(4 * i), 32'(i + 1));
    for (int i = 0; i < 4; i++) pr(regsem_pkg::OFS_RANGE + 8'(4 * i), 32'(i + 1));
    run();
    cmp("set_out", 32'h03, {24'h0, set_out});
    cmp("ctrl_out", 32'h33, {24'h0, ctrl_out});
    cmp("wonce_out", 32'hffff_ff44, wonce_out);
    cmp("applied_out", 32'h0, applied_out);
    pw(regsem_pkg::OFS_WONLY, 32'hdead_beef);
    run();
    cmp("op_start", 32'h1, {31'h0, op_start});
    cmp("cmd_out", 32'hdead_beef, cmd_out);
    put(1'h1, regsem_pkg::OFS_GPWR, 32'h1, 1'h0, 1'h1);
    run();
    cmp("gp_fault", 32'h1, {31'h0, gp_fault});
    hw(8'h00, 8'h00, 1'h1);
    pr(regsem_pkg::OFS_OPSTAT, 32'h1f);
    pw(regsem_pkg::OFS_WONLY, 32'h1);
    pr(regsem_pkg::OFS_OPSTAT, 32'h1e);
    run();
    hw(8'h04, 8'h01, 1'h0);
    pr(regsem_pkg::OFS_STATUS, 32'h04);
    pr(regsem_pkg::OFS_SETREG, 32'h02);
    pw(regsem_pkg::OFS_STATUS, 32'h0);
    pr(regsem_pkg::OFS_STATUS, 32'h04);
    pw(regsem_pkg::OFS_STATUS, 32'h04);
    pr(regsem_pkg::OFS_STATUS, 32'h0);
    run();
    rst(1'h0);
    pr(regsem_pkg::OFS_CTRL, 32'h0);
    pr(regsem_pkg::OFS_COLD, 32'h77);
    pw(regsem_pkg::OFS_WONCE, 32'h55);
    pr(regsem_pkg::OFS_WONCE, 32'h55);
    pr(regsem_pkg::OFS_VALUE, id_word);
    run();
    cmp("applied_out", 32'h99, applied_out);
    cmp("cold_out", 32'h77, cold_out);
    rst(1'h1);
    pr(regsem_pkg::OFS_COLD, 32'h0);
    run();
    cmp("applied_out", 32'h0, applied_out);
    test_done();
  end
endmodule // tb
